/* File: fsl_pkg.sv */
// fsl_pkg: constants shared by the flash security lock decoder.
// assumes a single 50 MHz clock and a synchronous active-high reset.
package fsl_pkg;
    localparam int unsigned FSL_CLK_HZ = 50_000_000;
    localparam int unsigned FSL_NUM_LOCK_BITS = 3;
    localparam int unsigned FSL_LOAD_CYCLES = 4;
    // wishbone register byte addresses
    localparam logic [3:0] FSL_ADDR_STATUS = 4'h0;
    localparam logic [3:0] FSL_ADDR_PROGRAM = 4'h4;
    localparam logic [3:0] FSL_ADDR_CONTROL = 4'h8;
    localparam logic [3:0] FSL_ADDR_REFUSED = 4'hc;
    // status fields
    localparam int unsigned FSL_ST_BITS_LSB = 0;
    localparam int unsigned FSL_ST_LEVEL_LSB = 4;
    localparam int unsigned FSL_ST_LOADED = 8;
    localparam int unsigned FSL_ST_UNDEF = 9;
    // control fields
    localparam int unsigned FSL_CT_FULL_ERASE = 0;
    localparam int unsigned FSL_CT_CLR_REFUSED = 1;
    // refused-operation sticky flags
    localparam int unsigned FSL_RF_TABLE = 0;
    localparam int unsigned FSL_RF_BLOCK = 1;
    localparam int unsigned FSL_RF_BOOT = 2;
    localparam int unsigned FSL_RF_VERIFY = 3;
    localparam int unsigned FSL_RF_EXT = 4;
    localparam int unsigned FSL_RF_W = 5;
    // protection levels: code 0..3 means level 1..4
    typedef enum logic [1:0] {
        FSL_LVL_1,
        FSL_LVL_2,
        FSL_LVL_3,
        FSL_LVL_4
    } fsl_level_e;
    localparam logic [2:0] FSL_PAT_L1 = 3'h0;
    localparam logic [2:0] FSL_PAT_L2 = 3'h1;
    localparam logic [2:0] FSL_PAT_L3 = 3'h3;
    localparam logic [2:0] FSL_PAT_L4 = 3'h7;
endpackage

/* File: fsl_level_decode.sv */
// fsl_level_decode: lock-bit pattern to protection level, combinational.
// assumes only the four defined patterns are ever programmed.
module fsl_level_decode
    import fsl_pkg::*;
(
    // lock bits, bit 0 is lock_bit_one
    input wire logic [2:0] lock_bits_i,
    // decoded level
    output fsl_pkg::fsl_level_e level_o,
    output logic undefined_o
);
    always_comb begin
        undefined_o = 1'b0;
        unique case (lock_bits_i)
            FSL_PAT_L1: level_o = FSL_LVL_1;
            FSL_PAT_L2: level_o = FSL_LVL_2;
            FSL_PAT_L3: level_o = FSL_LVL_3;
            FSL_PAT_L4: level_o = FSL_LVL_4;
            default: begin
                // undefined pattern: most restrictive level
                level_o = FSL_LVL_4;
                undefined_o = 1'b1;
            end
        endcase
    end
endmodule // fsl_level_decode

/* File: fsl_lock_decoder.sv */
// fsl_lock_decoder: holds the lock bits, decodes the level and gates
// cpu fetch and programmer operations. wishbone classic slave.
// assumes flash lock-bit store is given as a port sampled after reset.
//
// The placing of the registers and the Wishbone slave port were decided locally.
module fsl_lock_decoder
    import fsl_pkg::*;
#(
    parameter int unsigned LOAD_CYCLES = FSL_LOAD_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // non-volatile lock bit image
    input wire logic [2:0] flash_lock_bits_i,
    // cpu fetch and programmer requests
    input wire logic code_table_read_instruction_i,
    input wire logic fetch_from_external_i,
    input wire logic verify_req_i,
    input wire logic block_erase_req_i,
    input wire logic boot_prog_req_i,
    // grants
    output logic table_read_ok_o,
    output logic ext_exec_ok_o,
    output logic verify_ok_o,
    output logic block_erase_ok_o,
    output logic boot_prog_ok_o,
    output logic full_erase_o,
    output logic [2:0] lock_bits_o,
    output logic loaded_o
);
    import fsl_pkg::*;

// Overview of operation
// [RULE_01] level 1 blocks table reads from external code reading internal code
// [RULE_02] level 2 adds refusal of block erase commands
// [RULE_03] level 2 and above reject status byte or boot vector erase/program
// [RULE_04] level 3 adds refusal of code memory verify reads
// [RULE_05] level 4 adds refusal of execution from external program memory
// [RULE_06] each lock bit stored and programmed separately, none forces others
// [RULE_07] full-chip erase always accepted at any level
// [RULE_08] programmer uses only the four defined lock bit patterns
// [RULE_09] a set lock bit never blocks programming of unprogrammed bits
// [RULE_10] exactly three lock bits, the only inputs to level decode
// [RULE_11] lock bits loaded after reset before any request is judged

    typedef struct packed {
        logic [2:0] bits;
        logic loaded;
        logic [7:0] load_cnt;
        logic [FSL_RF_W-1:0] refused;
        logic table_ok;
        logic ext_ok;
        logic ver_ok;
        logic blk_ok;
        logic boot_ok;
        logic full_erase;
        logic ack;
        logic [31:0] rdata;
    } fsl_state_s;

    fsl_state_s state_q;
    fsl_state_s state_d;
    fsl_level_e level;
    logic undefined;
    logic bus_req;
    logic bus_wr;
    logic l2_up;
    logic l3_up;
    logic l4_up;
    logic [FSL_RF_W-1:0] refuse_now;

    fsl_level_decode u_decode (
        .lock_bits_i(state_q.bits), // [RULE_10]
        .level_o(level),
        .undefined_o(undefined)
    );

    assign bus_req = cyc_i && stb_i && !state_q.ack;
    assign bus_wr = bus_req && we_i && sel_i[0];
    assign l2_up = level != FSL_LVL_1;
    assign l3_up = level == FSL_LVL_3 || level == FSL_LVL_4;
    assign l4_up = level == FSL_LVL_4;

    always_comb begin
        refuse_now = '0;
        if (state_q.loaded) begin
            refuse_now[FSL_RF_TABLE] = code_table_read_instruction_i
                && fetch_from_external_i; // [RULE_01]
            refuse_now[FSL_RF_BLOCK] = block_erase_req_i && l2_up; // [RULE_02]
            refuse_now[FSL_RF_BOOT] = boot_prog_req_i && l2_up; // [RULE_03]
            refuse_now[FSL_RF_VERIFY] = verify_req_i && l3_up; // [RULE_04]
            refuse_now[FSL_RF_EXT] = fetch_from_external_i && l4_up; // [RULE_05]
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.ack = bus_req;
        state_d.full_erase = 1'b0;
        // load from flash image after reset
        if (!state_q.loaded) begin
            state_d.bits = flash_lock_bits_i; // [RULE_11]
            state_d.load_cnt = state_q.load_cnt + 8'h01;
            if (state_q.load_cnt == 8'(LOAD_CYCLES - 1)) begin
                state_d.loaded = 1'b1; // [RULE_11]
            end
        end
        // grants, all closed until loaded
        state_d.table_ok = state_d.loaded && !(code_table_read_instruction_i
            && fetch_from_external_i); // [RULE_01]
        state_d.ext_ok = state_d.loaded && !l4_up; // [RULE_05]
        state_d.ver_ok = state_d.loaded && !l3_up; // [RULE_04]
        state_d.blk_ok = state_d.loaded && !l2_up; // [RULE_02]
        state_d.boot_ok = state_d.loaded && !l2_up; // [RULE_03]
        // sticky refusals, set wins over clear
        if (bus_wr && adr_i == FSL_ADDR_CONTROL
            && dat_i[FSL_CT_CLR_REFUSED]) begin
            state_d.refused = '0;
        end
        state_d.refused = state_d.refused | refuse_now;
        if (bus_wr && state_q.loaded) begin
            if (adr_i == FSL_ADDR_PROGRAM) begin
                // set-only per bit; others unaffected
                state_d.bits = state_q.bits | dat_i[2:0]; // [RULE_06] [RULE_09]
            end else if (adr_i == FSL_ADDR_CONTROL
                && dat_i[FSL_CT_FULL_ERASE]) begin
                state_d.bits = '0; // [RULE_07]
                state_d.full_erase = 1'b1; // [RULE_07]
            end
        end
        state_d.rdata = '0;
        if (bus_req && !we_i) begin
            unique case (adr_i)
                FSL_ADDR_STATUS: begin
                    state_d.rdata[FSL_ST_BITS_LSB +: 3] = state_q.bits;
                    state_d.rdata[FSL_ST_LEVEL_LSB +: 2] = level;
                    state_d.rdata[FSL_ST_LOADED] = state_q.loaded;
                    state_d.rdata[FSL_ST_UNDEF] = undefined; // [RULE_08]
                end
                FSL_ADDR_PROGRAM: state_d.rdata[2:0] = state_q.bits;
                FSL_ADDR_REFUSED: state_d.rdata[FSL_RF_W-1:0] = state_q.refused;
                default: state_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign dat_o = state_q.rdata;
    assign ack_o = state_q.ack;
    assign table_read_ok_o = state_q.table_ok;
    assign ext_exec_ok_o = state_q.ext_ok;
    assign verify_ok_o = state_q.ver_ok;
    assign block_erase_ok_o = state_q.blk_ok;
    assign boot_prog_ok_o = state_q.boot_ok;
    assign full_erase_o = state_q.full_erase;
    assign lock_bits_o = state_q.bits;
    assign loaded_o = state_q.loaded;

    a_no_grant_unloaded: assert property (@(posedge clk_i) disable iff (rst_i)
        !loaded_o |-> !(ext_exec_ok_o || verify_ok_o || block_erase_ok_o)) // [RULE_11]
        else $error("grant before lock bits loaded");
    a_blk_erase_lvl2: assert property (@(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o[0] |=> !block_erase_ok_o) // [RULE_02]
        else $error("block erase granted at level 2");
    a_boot_prog_lvl2: assert property (@(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o != 3'h0 |=> !boot_prog_ok_o) // [RULE_03]
        else $error("boot vector programming granted above level 1");
    a_verify_lvl3: assert property (@(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o[1] |=> !verify_ok_o) // [RULE_04]
        else $error("verify granted at level 3");
    a_ext_exec_lvl4: assert property (@(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o == 3'h7 |=> !ext_exec_ok_o) // [RULE_05]
        else $error("external execution granted at level 4");
    a_table_read_blk: assert property (@(posedge clk_i) disable iff (rst_i)
        code_table_read_instruction_i && fetch_from_external_i
        |=> !table_read_ok_o) // [RULE_01]
        else $error("external table read of internal code granted");
    a_bits_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(loaded_o) && !full_erase_o
        |-> (lock_bits_o & $past(lock_bits_o)) == $past(lock_bits_o)) // [RULE_09]
        else $error("lock bit cleared without full erase");
    a_full_erase_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        full_erase_o |-> lock_bits_o == 3'h0) // [RULE_07]
        else $error("full erase did not clear lock bits");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held more than one cycle");

    // bus handshake
    a_ack_follows_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_needs_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_rdata_idle_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_write_reads_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(we_i) |-> dat_o == 32'h0)
        else $error("read data on write ack");
    a_unmapped_zero: assert property ( // [RULE_10]
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(!we_i) && $past(adr_i) != FSL_ADDR_STATUS
        && $past(adr_i) != FSL_ADDR_PROGRAM
        && $past(adr_i) != FSL_ADDR_REFUSED |-> dat_o == 32'h0)
        else $error("unmapped read not zero");

    // loading after reset
    a_loaded_sticky: assert property ( // [RULE_11]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o |=> loaded_o)
        else $error("loaded flag dropped");
    a_load_count: assert property ( // [RULE_11]
        @(posedge clk_i) disable iff (rst_i)
        !loaded_o |-> state_q.load_cnt < LOAD_CYCLES)
        else $error("load counter overran");
    a_bits_track_flash: assert property ( // [RULE_11]
        @(posedge clk_i) disable iff (rst_i)
        !state_q.loaded |=> lock_bits_o == $past(flash_lock_bits_i))
        else $error("lock bits not taken from flash image");

    // programming and erase
    a_program_sets: assert property ( // [RULE_06]
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(we_i) && $past(sel_i[0]) && $past(loaded_o)
        && $past(adr_i) == FSL_ADDR_PROGRAM
        |-> lock_bits_o == ($past(lock_bits_o) | $past(dat_i[2:0])))
        else $error("program write did not set requested bits");
    a_erase_any_level: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(we_i) && $past(sel_i[0]) && $past(loaded_o)
        && $past(adr_i) == FSL_ADDR_CONTROL && $past(dat_i[0])
        |-> full_erase_o)
        else $error("full erase refused");
    a_erase_only_cmd: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        full_erase_o |-> ack_o)
        else $error("full erase without command");

    // sticky refusals
    a_refused_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(bus_wr && adr_i == FSL_ADDR_CONTROL && dat_i[FSL_CT_CLR_REFUSED])
        |=> (state_q.refused & $past(state_q.refused))
        == $past(state_q.refused))
        else $error("refusal flag lost without clear");
    a_refuse_table: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && code_table_read_instruction_i && fetch_from_external_i
        |=> state_q.refused[FSL_RF_TABLE])
        else $error("table read refusal not flagged");
    a_refuse_block: assert property ( // [RULE_02]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && block_erase_req_i && lock_bits_o != 3'h0
        |=> state_q.refused[FSL_RF_BLOCK])
        else $error("block erase refusal not flagged");
    a_refuse_boot: assert property ( // [RULE_03]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && boot_prog_req_i && lock_bits_o != 3'h0
        |=> state_q.refused[FSL_RF_BOOT])
        else $error("boot vector refusal not flagged");
    a_refuse_verify: assert property ( // [RULE_04]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && verify_req_i && lock_bits_o[1]
        |=> state_q.refused[FSL_RF_VERIFY])
        else $error("verify refusal not flagged");
    a_refuse_ext: assert property ( // [RULE_05]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && fetch_from_external_i && lock_bits_o == 3'h7
        |=> state_q.refused[FSL_RF_EXT])
        else $error("external execution refusal not flagged");

    // grants where the level allows
    a_table_ok_free: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && !(code_table_read_instruction_i && fetch_from_external_i)
        |=> table_read_ok_o)
        else $error("table read wrongly blocked");
    a_blk_ok_lvl1: assert property ( // [RULE_02]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o == 3'h0 |=> block_erase_ok_o)
        else $error("block erase blocked at level 1");
    a_boot_ok_lvl1: assert property ( // [RULE_03]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o == 3'h0 |=> boot_prog_ok_o)
        else $error("boot programming blocked at level 1");
    a_verify_ok_low: assert property ( // [RULE_04]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && (lock_bits_o == 3'h0 || lock_bits_o == 3'h1)
        |=> verify_ok_o)
        else $error("verify blocked below level 3");
    a_ext_ok_lvl3: assert property ( // [RULE_05]
        @(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o == 3'h3 |=> ext_exec_ok_o)
        else $error("external execution blocked at level 3");

    // status and refusal reads
    a_status_bits: assert property ( // [RULE_10]
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(!we_i) && $past(adr_i) == FSL_ADDR_STATUS
        |-> dat_o[2:0] == $past(lock_bits_o))
        else $error("status read shows wrong lock bits");
    a_status_undef: assert property ( // [RULE_08]
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(!we_i) && $past(adr_i) == FSL_ADDR_STATUS
        |-> dat_o[FSL_ST_UNDEF]
        == !($past(lock_bits_o) inside {3'h0, 3'h1, 3'h3, 3'h7}))
        else $error("undefined pattern flag wrong");
    a_refused_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o && $past(!we_i) && $past(adr_i) == FSL_ADDR_REFUSED
        |-> dat_o[FSL_RF_W-1:0] == $past(state_q.refused))
        else $error("refusal read shows wrong flags");
    c_level4: cover property (@(posedge clk_i) disable iff (rst_i)
        loaded_o && lock_bits_o == 3'h7);
    c_full_erase: cover property (@(posedge clk_i) disable iff (rst_i)
        full_erase_o);
    c_refused: cover property (@(posedge clk_i) disable iff (rst_i)
        state_q.refused != '0);
    c_program_write: cover property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && state_q.loaded && adr_i == FSL_ADDR_PROGRAM);
    c_early_write: cover property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && !state_q.loaded);
endmodule // fsl_lock_decoder

/* File: fsl_flash_model.sv */
// fsl_flash_model: flash lock-bit image and cpu fetch/programmer requests.
// assumes the bench picks the level and switches requests on and off.
module fsl_flash_model (
    // selection
    input wire logic [1:0] level_sel_i,
    input wire logic req_on_i,
    // towards the decoder
    output logic [2:0] flash_lock_bits_o,
    output logic code_table_read_instruction_o,
    output logic fetch_from_external_i_o,
    output logic verify_req_o,
    output logic block_erase_req_o,
    output logic boot_prog_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        // only the four defined patterns are stored
        case (level_sel_i)
            2'h0: flash_lock_bits_o = 3'h0;
            2'h1: flash_lock_bits_o = 3'h1;
            2'h2: flash_lock_bits_o = 3'h3;
            default: flash_lock_bits_o = 3'h7;
        endcase
        code_table_read_instruction_o = req_on_i;
        fetch_from_external_i_o = req_on_i;
        verify_req_o = req_on_i;
        block_erase_req_o = req_on_i;
        boot_prog_req_o = req_on_i;
    end
endmodule // fsl_flash_model

/* File: flash_security_lock_decoder_test.sv */
// flash_security_lock_decoder_test: level decode, grants and bus checks.
// assumes a 50 MHz clock and the decoder with its default load count.
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module flash_security_lock_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fsl_pkg::*;
    logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, full_erase_o, loaded_o, req_on = 0;
    logic [1:0] level_sel = 2'h0;
    logic [2:0] flash_bits, lock_bits_o, pats[4];
    logic tbl, ext, ver, blk, bootp, tbl_ok, ext_ok, ver_ok, blk_ok, boot_ok;
    logic [4:0] g;
    int mismatches = 0, compares = 0, cycles = 0, erase_pulses = 0;
    always #10 clk_i = ~clk_i;
    fsl_flash_model fsl_flash_model_inst (.level_sel_i(level_sel),
        .req_on_i(req_on), .flash_lock_bits_o(flash_bits),
        .code_table_read_instruction_o(tbl), .fetch_from_external_i_o(ext),
        .verify_req_o(ver), .block_erase_req_o(blk), .boot_prog_req_o(bootp));
    fsl_lock_decoder fsl_lock_decoder_inst (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .flash_lock_bits_i(flash_bits), .code_table_read_instruction_i(tbl),
        .fetch_from_external_i(ext), .verify_req_i(ver),
        .block_erase_req_i(blk), .boot_prog_req_i(bootp),
        .table_read_ok_o(tbl_ok), .ext_exec_ok_o(ext_ok),
        .verify_ok_o(ver_ok), .block_erase_ok_o(blk_ok),
        .boot_prog_ok_o(boot_ok), .full_erase_o(full_erase_o),
        .lock_bits_o(lock_bits_o), .loaded_o(loaded_o));
    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (full_erase_o === 1'b1) erase_pulses++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; adr_i <= a; we_i <= w; dat_i <= d;
        sel_i <= 4'hf;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        if (n >= 50) mismatches++;
    endtask
    task automatic boot(input logic [1:0] l);
        int n = 0;
        @(posedge clk_i);
        rst_i <= 1; req_on <= 0; level_sel <= l;
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        // write before load must be ignored
        wb(FSL_ADDR_PROGRAM, 1, 32'h7);
        while (loaded_o !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        `CHK(n < 8, 1'b1)
        `CHK(lock_bits_o, pats[l])
    endtask
    initial begin
        pats = '{FSL_PAT_L1, FSL_PAT_L2, FSL_PAT_L3, FSL_PAT_L4};
        for (int l = 0; l < 4; l++) begin
            boot(l[1:0]);
            req_on <= 1;
            repeat (3) @(posedge clk_i);
            g = {l < 3, l < 2, l < 1, l < 1, 1'b0};
            `CHK({ext_ok, ver_ok, boot_ok, blk_ok, tbl_ok}, g)
            wb(FSL_ADDR_REFUSED, 0, 32'h0);
            `CHK(rd[4:0], ~g)
            wb(FSL_ADDR_STATUS, 0, 32'h0);
            `CHK(rd[5:4], l[1:0])
            $display("level %0d test done", l + 1);
        end
        req_on <= 0;
        wb(FSL_ADDR_CONTROL, 1, 32'h2);
        wb(FSL_ADDR_REFUSED, 0, 32'h0);
        `CHK(rd, 32'h0)
        wb(FSL_ADDR_CONTROL, 1, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK(erase_pulses, 1)
        `CHK(lock_bits_o, 3'h0)
        $display("full erase test done");
        wb(FSL_ADDR_PROGRAM, 1, 32'h1);
        wb(FSL_ADDR_STATUS, 0, 32'h0);
        `CHK(rd, 32'h111)
        wb(FSL_ADDR_PROGRAM, 1, 32'h2);
        wb(FSL_ADDR_PROGRAM, 1, 32'h4);
        wb(FSL_ADDR_PROGRAM, 0, 32'h0);
        `CHK(rd[2:0], 3'h7)
        wb(4'h2, 0, 32'h0);
        `CHK(rd, 32'h0)
        $display("programming test done");
        wrap_up();
    end
endmodule // flash_security_lock_decoder_test
